/* rtl/keypad_alarm.sv */
// keypad access controller with burglar alarm and avalon register port
// Function
// - heartbeat output toggles as 250 Hz square wave
// - recovery button at power-up enters program mode
// - program mode flashes red/green, yellow during option
// - program mode idle thirty seconds returns normal
// - hash aborts option; hash again leaves program
// - options 0-3 store master or user codes
// - options 4,5 set relay seconds, 0 latches
// - option 6 alarm seconds, 0000 disables loops
// - option 7 digit enables or disables panic
// - option 8 enables or disables one user code
// - settings stored, reloaded at power-up unless recovery held
// - alarm time zero ignores loops, armed light off
// - code one drives door relay, latch toggles
// - strike contact closure drives door relay too
// - code two drives auxiliary relay, own time
// - code three drives both relays, own times
// - valid code suspends loops, armed light flashes
// - star plus valid code rearms, no relay
// - five second digit gap or star/hash restarts
// - alarm from loop, four bad codes, panic
// - alarm relay for set time, indicator keeps flashing
// - any valid user code silences the alarm
// - star and hash together raise panic alarm
// - valid code clears the bad code counter
// - master code in normal enters program mode
module keypad_alarm
  import keypad_alarm_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [3:0] keypad_row_n,
  input wire logic [2:0] keypad_col_n,
  input wire logic recovery_button,
  input wire logic [1:0] alarm_loop_inputs,
  input wire logic external_strike_input,
  input wire logic nv_load_valid,
  input wire settings_t nv_load_data,
  output logic nv_store,
  output settings_t nv_store_data,
  output logic door_relay,
  output logic aux_relay,
  output logic alarm_relay,
  output logic armed_indicator,
  output logic green_indicator,
  output logic yellow_indicator,
  output logic alarm_indicator,
  output logic heartbeat_test_point
);
  core_t s_r, s_nxt;
  logic key_ev, panic_ev, door_go, aux_go, alarm_go, open_req;
  logic m1, m2, m3, loop_act;
  logic [3:0] key, dig;
  logic [11:0] fr;
  logic [15:0] code;
  logic [2:0] need;
  logic [13:0] a_sec;

  // handshake only: the answer is one cycle after the request appears
  assign avs_waitrequest = (avs_read | avs_write) & ~s_r.ack;
  assign avs_readdata = s_r.rdata;
  assign keypad_row_n = s_r.row_n;
  assign nv_store = s_r.nv_store;
  assign nv_store_data = s_r.cfg;
  assign door_relay = s_r.door_on;
  assign aux_relay = s_r.aux_on;
  assign alarm_relay = s_r.alarm_on;
  assign armed_indicator = s_r.led_red;
  assign green_indicator = s_r.led_green;
  assign yellow_indicator = s_r.led_yellow;
  assign alarm_indicator = s_r.led_alarm;
  assign heartbeat_test_point = s_r.hb;

  // next state of the whole controller
  always_comb begin
    s_nxt = s_r;
    s_nxt.ms_tick = 1'b0;
    s_nxt.sec_tick = 1'b0;
    s_nxt.nv_store = 1'b0;
    key_ev = 1'b0;
    panic_ev = 1'b0;
    door_go = 1'b0;
    aux_go = 1'b0;
    alarm_go = 1'b0;
    open_req = 1'b0;
    key = 4'h0;
    fr = {~keypad_col_n, s_r.frame[11:3]};
    code = {s_r.ebuf[11:0], 4'h0};
    dig = 4'h0;
    m1 = 1'b0;
    m2 = 1'b0;
    m3 = 1'b0;
    need = 3'h4;

    // millisecond and second enables
    if (s_r.ms_cnt == 18'(MS_CYC - 1)) begin
      s_nxt.ms_cnt = 18'h0;
      s_nxt.ms_tick = 1'b1;
    end else begin
      s_nxt.ms_cnt = s_r.ms_cnt + 18'h1;
    end
    if (s_r.ms_tick) begin
      if (s_r.msec == 10'(MS_PER_S - 1)) begin
        s_nxt.msec = 10'h0;
        s_nxt.sec_tick = 1'b1;
      end else begin
        s_nxt.msec = s_r.msec + 10'h1;
      end
      // toggle every 2 ms gives a 4 ms period
      if (s_r.hb_cnt == 2'(HB_HALF_MS - 1)) begin
        s_nxt.hb_cnt = 2'h0;
        s_nxt.hb = ~s_r.hb;
      end else begin
        s_nxt.hb_cnt = s_r.hb_cnt + 2'h1;
      end
      if (s_r.fl_cnt == 8'(FLASH_HALF_MS - 1)) begin
        s_nxt.fl_cnt = 8'h0;
        s_nxt.flash = ~s_r.flash;
      end else begin
        s_nxt.fl_cnt = s_r.fl_cnt + 8'h1;
      end
      // one row per ms; columns settle for a whole ms before sampling
      s_nxt.row = s_r.row + 2'h1;
      s_nxt.frame = fr;
    end
    s_nxt.row_n = ~(4'h1 << s_nxt.row);

    // a frame must repeat five times before it counts as stable
    if (s_r.ms_tick && s_r.row == 2'h3) begin
      if (fr != s_r.db_last) begin
        s_nxt.db_last = fr;
        s_nxt.db_cnt = 3'h0;
      end else if (s_r.db_cnt == 3'(DEBOUNCE_FRAMES - 1)) begin
        s_nxt.stable = fr;
        if (fr != s_r.stable && !s_r.lock) begin
          key_ev = (s_r.stable == 12'h0) && $onehot(fr);
          panic_ev = fr[9] && fr[11] && !(s_r.stable[9] && s_r.stable[11]);
        end
      end else begin
        s_nxt.db_cnt = s_r.db_cnt + 3'h1;
      end
    end
    for (int i = 0; i < 12; i++) begin
      if (fr[i]) begin
        key = 4'(i);
      end
    end
    dig = (key == KEY_ZERO) ? 4'h0 : key + 4'h1;
    code = {s_r.ebuf[11:0], dig};

    // seconds since the last key, saturating
    if (key_ev) begin
      s_nxt.idle_s = 5'h0;
    end else if (s_r.sec_tick && s_r.idle_s != 5'h1F) begin
      s_nxt.idle_s = s_r.idle_s + 5'h1;
    end

    // bus slave: read data latched on the first cycle, write at the ack
    s_nxt.ack = (avs_read | avs_write) & ~s_r.ack;
    if (avs_read && !s_r.ack) begin
      if (avs_address == ADDR_STATUS) begin
        s_nxt.rdata = {21'h0, s_r.lock, s_r.bad, s_r.suspended,
                       s_r.alarm_flag, s_r.alarm_on, s_r.aux_on,
                       s_r.door_on, s_r.mode};
      end else if (avs_address == ADDR_CTRL) begin
        s_nxt.rdata = {31'h0, s_r.lock};
      end else if (avs_address == ADDR_CFG) begin
        s_nxt.rdata = {4'h0, s_r.cfg.alarm_bcd, s_r.cfg.code_en,
                       s_r.cfg.panic_en, s_r.cfg.aux_s, s_r.cfg.door_s};
      end else begin
        s_nxt.rdata = 32'h0;
      end
    end
    if (avs_write && s_r.ack && avs_address == ADDR_CTRL) begin
      s_nxt.lock = avs_writedata[CTRL_LOCK_BIT];
      open_req = avs_writedata[CTRL_OPEN_BIT];
    end

    case (s_r.mode)
      M_LOAD: begin
        if (recovery_button) begin
          s_nxt.mode = M_PSEL;
          s_nxt.idle_s = 5'h0;
        end else if (nv_load_valid) begin
          s_nxt.cfg = nv_load_data;
          s_nxt.mode = M_NORMAL;
        end
      end
      M_NORMAL: begin
        if (external_strike_input && !s_r.strike_d) begin
          door_go = 1'b1;
        end
        if (open_req) begin
          door_go = 1'b1;
        end
        if ((s_r.ecnt != 3'h0 || s_r.star) &&
            s_r.idle_s >= 5'(DIGIT_TMO_S)) begin
          s_nxt.ecnt = 3'h0;
          s_nxt.star = 1'b0;
        end
        if (key_ev) begin
          if (key == KEY_STAR || key == KEY_HASH) begin
            s_nxt.ecnt = 3'h0;
            s_nxt.star = (key == KEY_STAR);
          end else if (s_r.ecnt != 3'h3) begin
            s_nxt.ebuf = code;
            s_nxt.ecnt = s_r.ecnt + 3'h1;
          end else begin
            s_nxt.ecnt = 3'h0;
            s_nxt.star = 1'b0;
            // master beats users, and user one beats two beats three
            m1 = s_r.cfg.code_en[0] && code == s_r.cfg.user_code_one;
            m2 = s_r.cfg.code_en[1] && code == s_r.cfg.user_code_two;
            m3 = s_r.cfg.code_en[2] && code == s_r.cfg.user_code_three;
            if (code == s_r.cfg.master_code) begin
              s_nxt.mode = M_PSEL;
              s_nxt.idle_s = 5'h0;
            end else if (m1 || m2 || m3) begin
              s_nxt.bad = 3'h0;
              s_nxt.alarm_on = 1'b0;
              s_nxt.alarm_flag = 1'b0;
              if (s_r.star) begin
                s_nxt.suspended = 1'b0;
              end else begin
                s_nxt.suspended = 1'b1;
                door_go = m1 || (!m2 && m3);
                aux_go = !m1 && (m2 || m3);
              end
            end else if (s_r.bad == 3'(BAD_LIMIT - 1)) begin
              s_nxt.bad = 3'h0;
              alarm_go = 1'b1;
            end else begin
              s_nxt.bad = s_r.bad + 3'h1;
            end
          end
        end
      end
      M_PSEL: begin
        if (s_r.idle_s >= 5'(PROG_TMO_S)) begin
          s_nxt.mode = M_NORMAL;
        end
        if (key_ev) begin
          if (key == KEY_HASH) begin
            s_nxt.mode = M_NORMAL;
          end else if (key != KEY_STAR && dig <= 4'h8) begin
            s_nxt.opt = dig;
            s_nxt.odig = 3'h0;
            s_nxt.mode = M_PDATA;
          end
        end
      end
      default: begin
        // option data: digit count depends on the option
        if (s_r.opt == 4'h4 || s_r.opt == 4'h5 || s_r.opt == 4'h7) begin
          need = 3'h1;
        end else if (s_r.opt == 4'h8) begin
          need = 3'h2;
        end
        if (s_r.idle_s >= 5'(DIGIT_TMO_S)) begin
          s_nxt.mode = M_PSEL;
          s_nxt.idle_s = 5'h0;
        end
        if (key_ev && key == KEY_HASH) begin
          s_nxt.mode = M_PSEL;
        end else if (key_ev && key != KEY_STAR) begin
          s_nxt.ebuf = code;
          s_nxt.odig = s_r.odig + 3'h1;
          if (s_r.odig + 3'h1 == need) begin
            s_nxt.mode = M_PSEL;
            s_nxt.nv_store = 1'b1;
            case (s_r.opt)
              4'h0: s_nxt.cfg.master_code = code;
              4'h1: begin
                s_nxt.cfg.user_code_one = code;
                s_nxt.cfg.code_en[0] = 1'b1;
              end
              4'h2: begin
                s_nxt.cfg.user_code_two = code;
                s_nxt.cfg.code_en[1] = 1'b1;
              end
              4'h3: begin
                s_nxt.cfg.user_code_three = code;
                s_nxt.cfg.code_en[2] = 1'b1;
              end
              4'h4: s_nxt.cfg.door_s = dig;
              4'h5: s_nxt.cfg.aux_s = dig;
              4'h6: s_nxt.cfg.alarm_bcd = code;
              4'h7: s_nxt.cfg.panic_en = (dig == 4'h1);
              default: begin
                if (s_r.ebuf[3:0] >= 4'h1 && s_r.ebuf[3:0] <= 4'h3) begin
                  s_nxt.cfg.code_en[2'(s_r.ebuf[3:0] - 4'h1)] =
                    (dig == 4'h1);
                end
              end
            endcase
          end
        end
      end
    endcase
    s_nxt.strike_d = external_strike_input;

    // loop and panic alarms are watched in every mode except M_LOAD
    loop_act = alarm_loop_inputs[0] | ~alarm_loop_inputs[1];
    if (s_r.mode != M_LOAD && s_r.cfg.alarm_bcd != 16'h0 &&
        !s_r.suspended && loop_act && !s_r.alarm_on) begin
      alarm_go = 1'b1;
    end
    if (panic_ev && s_r.cfg.panic_en && s_r.mode != M_LOAD) begin
      alarm_go = 1'b1;
    end

    // relay timers count whole seconds; a zero count means latched
    if (s_r.sec_tick && s_r.door_on && s_r.door_t != 4'h0) begin
      s_nxt.door_t = s_r.door_t - 4'h1;
      s_nxt.door_on = (s_r.door_t != 4'h1);
    end
    if (s_r.sec_tick && s_r.aux_on && s_r.aux_t != 4'h0) begin
      s_nxt.aux_t = s_r.aux_t - 4'h1;
      s_nxt.aux_on = (s_r.aux_t != 4'h1);
    end
    if (s_r.sec_tick && s_r.alarm_on) begin
      s_nxt.alarm_t = s_r.alarm_t - 14'h1;
      s_nxt.alarm_on = (s_r.alarm_t > 14'h1);
    end
    if (door_go) begin
      s_nxt.door_t = s_r.cfg.door_s;
      s_nxt.door_on = (s_r.cfg.door_s != 4'h0) || !s_r.door_on;
    end
    if (aux_go) begin
      s_nxt.aux_t = s_r.cfg.aux_s;
      s_nxt.aux_on = (s_r.cfg.aux_s != 4'h0) || !s_r.aux_on;
    end
    // loops off still leaves tamper and panic a fixed ten minutes
    a_sec = bcd_sec(s_r.cfg.alarm_bcd);
    if (alarm_go) begin
      s_nxt.alarm_on = 1'b1;
      s_nxt.alarm_flag = 1'b1;
      s_nxt.alarm_t = (a_sec == 14'h0) ? NOLOOP_ALARM_S : a_sec;
    end

    // indicators
    if (s_r.mode == M_PSEL || s_r.mode == M_PDATA) begin
      s_nxt.led_red = s_r.flash;
      s_nxt.led_green = s_r.flash;
      s_nxt.led_yellow = (s_r.mode == M_PDATA);
    end else begin
      s_nxt.led_red = (s_r.cfg.alarm_bcd != 16'h0) &&
                      (!s_r.suspended || s_r.flash);
      s_nxt.led_green = s_r.door_on;
      s_nxt.led_yellow = s_r.aux_on;
    end
    s_nxt.led_alarm = s_r.alarm_flag && s_r.flash;
  end

  // single state register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_r <= CORE_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

/* rtl/keypad_alarm_pkg.sv */
// constants, settings layout and state record of the keypad alarm
package keypad_alarm_pkg;
  localparam int CLK_NS = 5;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_NS;
  localparam int MS_PER_S = 1000;
  localparam int HB_HZ = 250;
  localparam int HB_HALF_MS = MS_PER_S / (2 * HB_HZ);
  localparam int FLASH_HALF_MS = 250;
  localparam int DEBOUNCE_FRAMES = 5;
  localparam int DIGIT_TMO_S = 5;
  localparam int PROG_TMO_S = 30;
  localparam int BAD_LIMIT = 4;
  localparam logic [13:0] NOLOOP_ALARM_S = 14'h258;
  localparam logic [3:0] KEY_STAR = 4'h9;
  localparam logic [3:0] KEY_ZERO = 4'hA;
  localparam logic [3:0] KEY_HASH = 4'hB;
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h4;
  localparam logic [3:0] ADDR_CFG = 4'h8;
  localparam int CTRL_LOCK_BIT = 0;
  localparam int CTRL_OPEN_BIT = 1;

  typedef enum logic [1:0] {M_LOAD, M_NORMAL, M_PSEL, M_PDATA} mode_t;

  // everything kept in nonvolatile storage
  typedef struct packed {
    logic [15:0] master_code;
    logic [15:0] user_code_one;
    logic [15:0] user_code_two;
    logic [15:0] user_code_three;
    logic [3:0] door_s;
    logic [3:0] aux_s;
    logic [15:0] alarm_bcd;
    logic panic_en;
    logic [2:0] code_en;
  } settings_t;

  // whole state of the controller
  typedef struct packed {
    mode_t mode;
    settings_t cfg;
    logic [17:0] ms_cnt;
    logic ms_tick;
    logic [9:0] msec;
    logic sec_tick;
    logic [1:0] hb_cnt;
    logic hb;
    logic [7:0] fl_cnt;
    logic flash;
    logic [1:0] row;
    logic [3:0] row_n;
    logic [11:0] frame, db_last, stable;
    logic [2:0] db_cnt;
    logic [15:0] ebuf;
    logic [2:0] ecnt;
    logic star;
    logic [4:0] idle_s;
    logic [3:0] opt;
    logic [2:0] odig;
    logic door_on;
    logic [3:0] door_t;
    logic aux_on;
    logic [3:0] aux_t;
    logic alarm_on;
    logic [13:0] alarm_t;
    logic alarm_flag;
    logic suspended;
    logic [2:0] bad;
    logic lock;
    logic ack;
    logic [31:0] rdata;
    logic nv_store;
    logic strike_d;
    logic led_red, led_green, led_yellow, led_alarm;
  } core_t;

  localparam core_t CORE_RESET = '0;

  // four bcd digits of seconds to binary
  function automatic logic [13:0] bcd_sec(input logic [15:0] b);
    bcd_sec = 14'(b[15:12]) * 14'h3E8 + 14'(b[11:8]) * 14'h64
            + 14'(b[7:4]) * 14'hA + 14'(b[3:0]);
  endfunction
endpackage

/* bench/keypad_alarm_monitor.sv */
// port checker of the keypad alarm controller, bound into it
module keypad_alarm_monitor
  import keypad_alarm_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [3:0] keypad_row_n,
  input wire logic nv_store,
  input wire settings_t nv_store_data,
  input wire logic door_relay,
  input wire logic alarm_relay,
  input wire logic alarm_indicator,
  input wire logic heartbeat_test_point
);
  localparam int S = 1000 * MS_CYC;
  localparam int HB = 2 * MS_CYC;
  localparam int FL = 250 * MS_CYC + 4;
  logic [1:0] up_r;
  logic hb_seen_r;
  logic [31:0] hb_r, door_r, al_r, al_lim, door_lim, dark_r;
  logic [15:0] b;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // stored seconds as cycles; the limits follow the live settings
  assign b = nv_store_data.alarm_bcd;
  assign al_lim = (32'(b[15:12]) * 1000 + 32'(b[11:8]) * 100
    + 32'(b[7:4]) * 10 + 32'(b[3:0])) * S;
  assign door_lim = 32'(nv_store_data.door_s) * S;
  // time since reset, since the last heartbeat edge, and relay on-times
  always_ff @(posedge core_clk) begin
    if (srst) begin
      up_r <= 2'h0;
      hb_seen_r <= 1'b0;
      hb_r <= '0;
      door_r <= '0;
      al_r <= '0;
      dark_r <= '0;
    end else begin
      up_r <= up_r == 2'h3 ? up_r : up_r + 2'h1;
      hb_seen_r <= hb_seen_r | $changed(heartbeat_test_point);
      hb_r <= $changed(heartbeat_test_point) ? '0 : hb_r + 32'h1;
      door_r <= door_relay ? door_r + 32'h1 : '0;
      al_r <= alarm_relay ? al_r + 32'h1 : '0;
      // dark run of the alarm light while the relay is on; a counter
      // because half a flash period is far too long for a delay range
      dark_r <= alarm_relay && !alarm_indicator ? dark_r + 32'h1 : '0;
    end
  end
  property p_hb;
    hb_seen_r |-> hb_r < HB
      && (!$changed(heartbeat_test_point) || hb_r == HB - 1);
  endproperty
  a_hb: assert property (p_hb) else $error("heartbeat period");
  property p_wait;
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus wait cycle count");
  property p_row_one;
    up_r == 2'h3 |-> $onehot(~keypad_row_n);
  endproperty
  a_row_one: assert property (p_row_one) else $error("row drive");
  property p_row_hold;
    up_r == 2'h3 && $changed(keypad_row_n) |=> $stable(keypad_row_n);
  endproperty
  a_row_hold: assert property (p_row_hold) else $error("row dwell");
  property p_nv;
    nv_store |=> !nv_store;
  endproperty
  a_nv: assert property (p_nv) else $error("store pulse width");
  property p_door;
    $fell(door_relay) && nv_store_data.door_s != 4'h0
      |-> door_r <= door_lim + 4 && door_r + S + 4 >= door_lim;
  endproperty
  a_door: assert property (p_door) else $error("door time");
  property p_alarm;
    alarm_relay && b != 16'h0 |-> al_r <= al_lim + 4;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm time");
  property p_alarm_led;
    alarm_relay |-> dark_r < FL;
  endproperty
  a_alarm_led: assert property (p_alarm_led) else $error("alarm led");
endmodule

bind keypad_alarm keypad_alarm_monitor #(.MS_CYC(MS_CYC)) i_mon (
  .core_clk, .srst, .avs_read, .avs_write, .avs_waitrequest,
  .keypad_row_n, .nv_store, .nv_store_data, .door_relay, .alarm_relay,
  .alarm_indicator, .heartbeat_test_point);

/* bench/keypad_matrix_model.sv */
// matrix keypad with pull-ups on the column lines, up to two keys held
module keypad_matrix_model (
  input wire logic [3:0] keypad_row_n,
  input wire logic [3:0] key_a,
  input wire logic [3:0] key_b,
  output logic [2:0] keypad_col_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // a held key joins its row to its column; open columns float high
  always_comb begin
    keypad_col_n = 3'h7;
    for (int k = 0; k < 12; k++) begin
      if ((key_a == 4'(k) || key_b == 4'(k)) && !keypad_row_n[k / 3]) begin
        keypad_col_n[k % 3] = 1'b0;
      end
    end
  end
endmodule

/* bench/keypad_alarm_tb.sv */
// self-checking bench of the keypad alarm controller
`define CHK(n, e, g) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); \
  end \
end
module keypad_alarm_tb
  import keypad_alarm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MSC = 2;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0, avs_readdata, q;
  logic avs_waitrequest, nv_store, recovery_button = 1'b1;
  logic [3:0] keypad_row_n, key_a = 4'hF, key_b = 4'hF;
  logic [2:0] keypad_col_n;
  logic external_strike_input = 1'b0, nv_load_valid = 1'b0;
  logic [1:0] alarm_loop_inputs = 2'h2;
  settings_t nv_load_data = '0, nv_store_data, exp;
  logic door_relay, aux_relay, alarm_relay, armed_indicator;
  logic green_indicator, yellow_indicator, alarm_indicator;
  logic heartbeat_test_point;
  int bad_count = 0, num_checks = 0, n, stores = 0;
  logic [19:0] tbl [9] = '{20'h01234, 20'h15678, 20'h21111, 20'h32222,
    20'h40002, 20'h50000, 20'h60002, 20'h70001, 20'h80030};

  keypad_alarm #(.MS_CYC(MSC)) i_dut (.core_clk, .srst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .keypad_row_n, .keypad_col_n, .recovery_button, .alarm_loop_inputs,
    .external_strike_input, .nv_load_valid, .nv_load_data, .nv_store,
    .nv_store_data, .door_relay, .aux_relay, .alarm_relay, .armed_indicator,
    .green_indicator, .yellow_indicator, .alarm_indicator,
    .heartbeat_test_point);
  keypad_matrix_model i_pad (.keypad_row_n, .key_a, .key_b, .keypad_col_n);

  initial forever #2.5 core_clk = ~core_clk;

  // store pulses seen, one expected per finished option
  always @(posedge core_clk) begin
    if (nv_store === 1'b1) stores++;
  end

  task automatic ms(input int m);
    repeat (m * MSC) @(posedge core_clk);
  endtask
  // one access; the request stands until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] r);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    // data and write both belong to the edge that saw waitrequest low
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  function automatic logic [3:0] key_of(input logic [3:0] d);
    return d == 4'h0 ? KEY_ZERO : d - 4'h1;
  endfunction
  // press and release long enough for both to pass the debounce
  task automatic hit(input logic [3:0] k);
    key_a <= k;
    ms(32);
    key_a <= 4'hF;
    ms(32);
  endtask
  task automatic digs(input logic [15:0] d, input int c);
    for (int i = c - 1; i >= 0; i--) hit(key_of(d[i * 4 +: 4]));
  endtask
  // counts level changes of one indicator over 600 ms
  task automatic flash(input int w, output int c);
    logic p, s;
    c = 0;
    p = 1'b0;
    for (int i = 0; i < 600 * MSC; i++) begin
      @(posedge core_clk);
      s = w == 0 ? armed_indicator
        : (w == 1 ? green_indicator : alarm_indicator);
      if (i > 0 && s !== p) c++;
      p = s;
    end
  endtask
  task automatic done(input string s);
    $display("[TEST] %s done", s);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // watchdog well past the expected run of about 100k cycles
  initial begin
    #800000;
    bad_count++;
    finish_test();
  end

  initial begin
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    ms(2);
    recovery_button <= 1'b0;
    bus(1'b0, ADDR_STATUS, '0, q);
    `CHK("mode", 2'h2, q[1:0])
    for (int w = 0; w < 2; w++) begin
      flash(w, n);
      `CHK("prog_flash", 1'b1, n >= 2)
    end
    foreach (tbl[i]) begin
      hit(key_of(tbl[i][19:16]));
      `CHK("yellow_on", 1'b1, yellow_indicator)
      digs(tbl[i][15:0], tbl[i][19:16] < 4 || tbl[i][19:16] == 6 ? 4
        : (tbl[i][19:16] == 8 ? 2 : 1));
      `CHK("yellow_off", 1'b0, yellow_indicator)
    end
    hit(key_of(4'h4));
    hit(KEY_HASH);
    `CHK("abort", 1'b0, yellow_indicator)
    hit(KEY_HASH);
    bus(1'b0, ADDR_STATUS, '0, q);
    `CHK("mode", 2'h1, q[1:0])
    exp = '{master_code: 16'h1234, user_code_one: 16'h5678,
      user_code_two: 16'h1111, user_code_three: 16'h2222, door_s: 4'h2,
      aux_s: 4'h0, alarm_bcd: 16'h0002, panic_en: 1'b1, code_en: 3'h3};
    `CHK("nv", exp, nv_store_data)
    `CHK("stores", 9, stores)
    done("program");
    srst <= 1'b1;
    nv_load_valid <= 1'b1;
    nv_load_data <= exp;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    ms(2);
    bus(1'b0, ADDR_CFG, '0, q);
    `CHK("cfg", {4'h0, exp.alarm_bcd, exp.code_en, exp.panic_en, exp.aux_s,
      exp.door_s}, q)
    flash(0, n);
    `CHK("armed", 2'h1, {n != 0, armed_indicator})
    bus(1'b1, ADDR_CTRL, 32'h1, q);
    bus(1'b0, ADDR_CTRL, '0, q);
    `CHK("ctrl", 32'h1, q)
    bus(1'b1, ADDR_CTRL, 32'h0, q);
    bus(1'b0, 4'hC, '0, q);
    `CHK("unmapped", 32'h0, q)
    external_strike_input <= 1'b1;
    ms(4);
    `CHK("strike", 1'b1, door_relay)
    external_strike_input <= 1'b0;
    ms(2200);
    done("reload");
    digs(16'h2222, 4);
    bus(1'b0, ADDR_STATUS, '0, q);
    `CHK("off_code", 4'h2, {q[9:7], door_relay})
    digs(16'h5678, 4);
    `CHK("door", 2'h3, {door_relay, green_indicator})
    bus(1'b0, ADDR_STATUS, '0, q);
    `CHK("bad_susp", 4'h1, {q[9:7], q[6]})
    ms(800);
    `CHK("door_hold", 1'b1, door_relay)
    flash(0, n);
    `CHK("susp_flash", 1'b1, n >= 2)
    ms(800);
    `CHK("door_end", 1'b0, door_relay)
    digs(16'h1111, 4);
    `CHK("aux", 2'h3, {aux_relay, yellow_indicator})
    bus(1'b1, ADDR_CTRL, 32'h2, q);
    `CHK("open", 1'b1, door_relay)
    ms(1500);
    `CHK("aux_latch", 1'b1, aux_relay)
    digs(16'h1111, 4);
    `CHK("aux_drop", 1'b0, aux_relay)
    done("codes");
    hit(KEY_STAR);
    digs(16'h5678, 4);
    bus(1'b0, ADDR_STATUS, '0, q);
    `CHK("rearm", 3'h1, {q[6], door_relay, armed_indicator})
    alarm_loop_inputs <= 2'h0;
    ms(20);
    `CHK("loop", 1'b1, alarm_relay)
    alarm_loop_inputs <= 2'h2;
    hit(KEY_STAR);
    digs(16'h5678, 4);
    bus(1'b0, ADDR_STATUS, '0, q);
    `CHK("silence", 2'h0, {alarm_relay, q[5]})
    key_a <= KEY_STAR;
    key_b <= KEY_HASH;
    ms(32);
    key_b <= 4'hF;
    hit(4'hF);
    `CHK("panic", 1'b1, alarm_relay)
    digs(16'h5678, 4);
    `CHK("silence", 1'b0, alarm_relay)
    for (int i = 0; i < 4; i++) digs(16'h9999, 4);
    `CHK("tamper", 1'b1, alarm_relay)
    flash(2, n);
    `CHK("alarm_flash", 1'b1, n >= 2)
    ms(1700);
    `CHK("alarm_end", 1'b0, alarm_relay)
    flash(2, n);
    `CHK("still_flash", 1'b1, n >= 2)
    digs(16'h0056, 2);
    hit(KEY_HASH);
    digs(16'h5678, 4);
    bus(1'b0, ADDR_STATUS, '0, q);
    `CHK("restart", 3'h4, {door_relay, q[5], alarm_indicator})
    done("alarms");
    ms(2200);
    digs(16'h1234, 4);
    bus(1'b0, ADDR_STATUS, '0, q);
    `CHK("master", 2'h2, q[1:0])
    ms(31000);
    bus(1'b0, ADDR_STATUS, '0, q);
    `CHK("idle_exit", 2'h1, q[1:0])
    done("program_timeout");
    finish_test();
  end
endmodule
